// *** hdl/pecx_params.svh ***
// Register offsets, field positions, reset values for the error counter and extended control block
`ifndef PECX_PARAMS_SVH
`define PECX_PARAMS_SVH
`define PECX_ADDR_RXERR      5'h13
`define PECX_ADDR_FCAR       5'h14
`define PECX_ADDR_DISC       5'h15
`define PECX_ADDR_EXTCS      5'h16
`define PECX_ADDR_MEDIA      5'h17
`define PECX_CNT_MAX         8'hff
`define PECX_BIT_FORCE_LINK  15
`define PECX_BIT_JABBER_DIS  14
`define PECX_BIT_ECHO_DIS    13
`define PECX_BIT_SQE_DIS     12
`define PECX_BIT_SQ_HI       11
`define PECX_BIT_SQ_LO       10
`define PECX_BIT_RETAIN      9
`define PECX_BIT_EOF_ERR     8
`define PECX_BIT_TEN_DISC    7
`define PECX_BIT_TEN_LINK    6
`define PECX_BIT_BCAST       0
`define PECX_BIT_MAC_MODE    12
`define PECX_BIT_PREF        11
`define PECX_BIT_MODE_HI     10
`define PECX_BIT_MODE_LO     8
`define PECX_BIT_OVR_HI      7
`define PECX_BIT_OVR_LO      6
`define PECX_BIT_FELB        3
`define PECX_RST_EXTCS_CTL   16'h3200
`define PECX_RST_MODE        5'h00
`endif

// *** hdl/pecx_pkg.sv ***
// Types for the error counter and extended control block
package pecx_pkg;
  typedef enum logic [1:0] {PECX_SQ_NORMAL, PECX_SQ_LOW, PECX_SQ_HIGH, PECX_SQ_RSVD} pecx_squelch_type;
  typedef enum logic [2:0] {PECX_MM_COPPER, PECX_MM_SERDES, PECX_MM_1000X, PECX_MM_100FX,
                            PECX_MM_RSVD, PECX_MM_AMS_SERDES, PECX_MM_AMS_1000X, PECX_MM_AMS_100FX} pecx_media_type;
  typedef enum logic [1:0] {PECX_OV_NORMAL, PECX_OV_SERDES, PECX_OV_COPPER, PECX_OV_RSVD} pecx_override_type;
endpackage

// *** hdl/pecx_cnt_if.sv ***
// Interface between the register bank and one saturating counter
`timescale 1ns/1ps
`default_nettype none
interface pecx_cnt_if;
  logic       event_hit;
  logic       clear;
  logic [7:0] count;
  modport bank (output event_hit, output clear, input count);
  modport cnt  (input event_hit, input clear, output count);
endinterface
`default_nettype wire

// *** hdl/pecx_sat_counter.sv ***
// Saturating 8-bit clear-on-read error counter
`timescale 1ns/1ps
`default_nettype none
`include "pecx_params.svh"
module pecx_sat_counter
  import pecx_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  pecx_cnt_if.cnt   port_if
);
  // An event in the read cycle counts as one after the clear, so it is not lost
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      port_if.count <= 8'h00;
    else if (port_if.clear)
      port_if.count <= {7'h00, port_if.event_hit};
    else if (port_if.event_hit && port_if.count != `PECX_CNT_MAX)
      port_if.count <= port_if.count + 8'h01;
  end
endmodule
`default_nettype wire

// *** hdl/pecx_regs.sv ***
// Management register bank, addresses 19 to 23, of one PHY port
//
// Contract
// - Counters are 8-bit, saturate at 255
// - Counter read returns count, then clears
// - Address 19 counts 100/1000 receive errors
// - Address 20 counts 100/1000 false carriers
// - Address 21 counts copper link disconnects
// - Bit 22.15 forces 10BASE-T link pass
// - Bits 14..12 disable jabber, echo, SQE
// - Squelch field 11:10 selects threshold
// - Retain bit set keeps sticky bits
// - Retain clear restores sticky defaults on reset
// - Super-sticky bits survive every software reset
// - EOF error and disconnect flags clear-on-read
// - Bit 22.6 shows 10BASE-T link status
// - Broadcast bit sends writes to all PHYs
// - Reads stay local during broadcast mode
// - Bit 23.12 selects SGMII or 1000BASE-X
// - Bit 23.11 sets media sense preference
// - Bits 10:8 select media operating mode
// - Bits 7:6 override automatic media selection
// - Mode bits read the mode in force
`timescale 1ns/1ps
`default_nettype none
`include "pecx_params.svh"
module pecx_regs
  import pecx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        soft_reset,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_bcast_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  output logic             bcast_enable,
  input  wire logic        rx_error_event,
  input  wire logic        false_carrier_event,
  input  wire logic        copper_disc_event,
  input  wire logic        eof_error_event,
  input  wire logic        ten_disc_event,
  input  wire logic        ten_link_active,
  output logic             force_link_pass,
  output logic             jabber_disable,
  output logic             echo_disable,
  output logic             sqe_disable,
  output pecx_squelch_type squelch_mode,
  output logic             mac_1000x,
  output logic             auto_media_sense_pref_copper,
  output pecx_media_type   media_mode,
  output pecx_override_type media_override,
  output logic             far_end_loopback
);

  // ==========================================================
  // Write decode
  // ==========================================================
  // A broadcast write from a sibling PHY lands here just like a local one
  logic wr_any;
  logic wr_extcs;
  logic wr_media;
  logic rd_extcs;

  assign wr_any   = mgmt_wr | mgmt_bcast_wr;
  assign wr_extcs = wr_any && mgmt_addr == `PECX_ADDR_EXTCS;
  assign wr_media = wr_any && mgmt_addr == `PECX_ADDR_MEDIA;
  assign rd_extcs = mgmt_rd && mgmt_addr == `PECX_ADDR_EXTCS;

  // ==========================================================
  // Error counters
  // ==========================================================
  pecx_cnt_if cnt_if [3] ();
  logic [2:0] cnt_event;
  logic [4:0] cnt_addr [3];

  assign cnt_event[0] = rx_error_event;
  assign cnt_event[1] = false_carrier_event;
  assign cnt_event[2] = copper_disc_event;
  assign cnt_addr[0]  = `PECX_ADDR_RXERR;
  assign cnt_addr[1]  = `PECX_ADDR_FCAR;
  assign cnt_addr[2]  = `PECX_ADDR_DISC;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cnt
      assign cnt_if[gi].event_hit = cnt_event[gi];
      assign cnt_if[gi].clear     = mgmt_rd && mgmt_addr == cnt_addr[gi];
      pecx_sat_counter u_cnt
      (
        .sys_clk (sys_clk),
        .rst     (rst),
        .port_if (cnt_if[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Register 22 reset image
  // ==========================================================
  // Every sticky field and retain default comes from this one word, so fields and read-back agree
  localparam logic [15:0] extcs_default = `PECX_RST_EXTCS_CTL;

  // ==========================================================
  // Register 22 super-sticky retain enable
  // ==========================================================
  logic sticky_retain;

  // Only a hard reset returns it to its default
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sticky_retain <= extcs_default[`PECX_BIT_RETAIN];
    else if (wr_extcs)
      sticky_retain <= mgmt_wdata[`PECX_BIT_RETAIN];
  end

  // ==========================================================
  // Register 22 sticky control fields
  // ==========================================================
  logic [1:0] squelch_bits;
  logic       sticky_default;
  logic       sticky_write;

  // A write that meets a software reset is dropped, so the reset outcome is predictable
  assign sticky_default = soft_reset && !sticky_retain;
  assign sticky_write   = wr_extcs && !soft_reset;

  always_ff @(posedge sys_clk)
  begin
    if (rst || sticky_default)
      force_link_pass <= extcs_default[`PECX_BIT_FORCE_LINK];
    else if (sticky_write)
      force_link_pass <= mgmt_wdata[`PECX_BIT_FORCE_LINK];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || sticky_default)
      jabber_disable <= extcs_default[`PECX_BIT_JABBER_DIS];
    else if (sticky_write)
      jabber_disable <= mgmt_wdata[`PECX_BIT_JABBER_DIS];
  end

  // Echo and SQE come out of reset disabled
  always_ff @(posedge sys_clk)
  begin
    if (rst || sticky_default)
      echo_disable <= extcs_default[`PECX_BIT_ECHO_DIS];
    else if (sticky_write)
      echo_disable <= mgmt_wdata[`PECX_BIT_ECHO_DIS];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || sticky_default)
      sqe_disable <= extcs_default[`PECX_BIT_SQE_DIS];
    else if (sticky_write)
      sqe_disable <= mgmt_wdata[`PECX_BIT_SQE_DIS];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || sticky_default)
      squelch_bits <= extcs_default[`PECX_BIT_SQ_HI:`PECX_BIT_SQ_LO];
    else if (sticky_write)
      squelch_bits <= mgmt_wdata[`PECX_BIT_SQ_HI:`PECX_BIT_SQ_LO];
  end

  // The broadcast enable is sticky like the line controls
  always_ff @(posedge sys_clk)
  begin
    if (rst || sticky_default)
      bcast_enable <= extcs_default[`PECX_BIT_BCAST];
    else if (sticky_write)
      bcast_enable <= mgmt_wdata[`PECX_BIT_BCAST];
  end

  // Reserved code 11 is stored and passed out on squelch_mode as PECX_SQ_RSVD
  assign squelch_mode = pecx_squelch_type'(squelch_bits);

  // ==========================================================
  // Register 22 event flags
  // ==========================================================
  logic eof_error_flag;
  logic ten_disc_flag;

  // Set wins over the clear-on-read so an event in the read cycle is kept
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      eof_error_flag <= 1'b0;
    else
      eof_error_flag <= eof_error_event | (eof_error_flag & ~rd_extcs);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ten_disc_flag <= 1'b0;
    else
      ten_disc_flag <= ten_disc_event | (ten_disc_flag & ~rd_extcs);
  end

  // ==========================================================
  // Register 22 link status
  // ==========================================================
  logic ten_link_q;

  // A forced link pass reads as link up, one cycle behind the line
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ten_link_q <= 1'b0;
    else
      ten_link_q <= ten_link_active | force_link_pass;
  end

  // ==========================================================
  // Register 23 mode bits
  // ==========================================================
  logic [4:0] mode_pending;
  logic [4:0] mode_active;

  // Bits 12:8 are super-sticky; a written value waits for a software reset
  // Bit 13 is reserved and has no storage, so it reads zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mode_pending <= `PECX_RST_MODE;
    else if (wr_media)
      mode_pending <= mgmt_wdata[`PECX_BIT_MAC_MODE:`PECX_BIT_MODE_LO];
  end

  // The soft reset is the only way a new mode takes hold
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mode_active <= `PECX_RST_MODE;
    else if (soft_reset)
      mode_active <= mode_pending;
  end

  // ==========================================================
  // Register 23 immediate fields
  // ==========================================================
  logic [1:0] override_bits;

  // Override and loopback act at once, with no soft reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      override_bits <= 2'h0;
    else if (wr_media)
      override_bits <= mgmt_wdata[`PECX_BIT_OVR_HI:`PECX_BIT_OVR_LO];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      far_end_loopback <= 1'b0;
    else if (wr_media)
      far_end_loopback <= mgmt_wdata[`PECX_BIT_FELB];
  end

  // ==========================================================
  // Register 23 decoded outputs
  // ==========================================================
  // Mode outputs follow the active copy only
  assign mac_1000x                    = mode_active[`PECX_BIT_MAC_MODE - 8];
  assign auto_media_sense_pref_copper = mode_active[`PECX_BIT_PREF - 8];
  assign media_mode                   = pecx_media_type'(mode_active[2:0]);
  assign media_override               = pecx_override_type'(override_bits);

  // ==========================================================
  // Read words
  // ==========================================================
  logic [15:0] extcs_word;
  logic [15:0] media_word;
  logic [15:0] read_word;

  // Reserved positions stay zero
  always_comb
  begin
    extcs_word                                  = 16'h0000;
    extcs_word[`PECX_BIT_FORCE_LINK]            = force_link_pass;
    extcs_word[`PECX_BIT_JABBER_DIS]            = jabber_disable;
    extcs_word[`PECX_BIT_ECHO_DIS]              = echo_disable;
    extcs_word[`PECX_BIT_SQE_DIS]               = sqe_disable;
    extcs_word[`PECX_BIT_SQ_HI:`PECX_BIT_SQ_LO] = squelch_bits;
    extcs_word[`PECX_BIT_RETAIN]                = sticky_retain;
    extcs_word[`PECX_BIT_EOF_ERR]               = eof_error_flag;
    extcs_word[`PECX_BIT_TEN_DISC]              = ten_disc_flag;
    extcs_word[`PECX_BIT_TEN_LINK]              = ten_link_q;
    extcs_word[`PECX_BIT_BCAST]                 = bcast_enable;
  end

  // Bits 15:13 read zero
  always_comb
  begin
    media_word                                       = 16'h0000;
    media_word[`PECX_BIT_MAC_MODE:`PECX_BIT_MODE_LO] = mode_active;
    media_word[`PECX_BIT_OVR_HI:`PECX_BIT_OVR_LO]    = override_bits;
    media_word[`PECX_BIT_FELB]                       = far_end_loopback;
  end

  // Unmapped addresses read zero
  always_comb
  begin
    if (mgmt_addr == `PECX_ADDR_RXERR)
      read_word = {8'h00, cnt_if[0].count};
    else if (mgmt_addr == `PECX_ADDR_FCAR)
      read_word = {8'h00, cnt_if[1].count};
    else if (mgmt_addr == `PECX_ADDR_DISC)
      read_word = {8'h00, cnt_if[2].count};
    else if (mgmt_addr == `PECX_ADDR_EXTCS)
      read_word = extcs_word;
    else if (mgmt_addr == `PECX_ADDR_MEDIA)
      read_word = media_word;
    else
      read_word = 16'h0000;
  end

  // ==========================================================
  // Read register
  // ==========================================================
  // Only this port's values are returned, broadcast mode or not
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mgmt_rdata <= 16'h0000;
    else if (mgmt_rd)
      mgmt_rdata <= read_word;
  end
endmodule
`default_nettype wire

// *** tb/pecx_host.sv ***
// Management host model that issues register accesses
`timescale 1ns/1ps
`default_nettype none
module pecx_host
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] mgmt_rdata,
  output logic             soft_reset,
  output logic [4:0]       mgmt_addr,
  output logic             mgmt_wr,
  output logic             mgmt_bcast_wr,
  output logic             mgmt_rd,
  output logic [15:0]      mgmt_wdata
);
  initial {soft_reset, mgmt_addr, mgmt_wr, mgmt_bcast_wr, mgmt_rd, mgmt_wdata} = '0;
  // Falling-edge strobes, so each is taken at one rising edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic b);
    @(negedge sys_clk);
    {mgmt_addr, mgmt_wdata, mgmt_wr, mgmt_bcast_wr} = {a, d, !b, b};
    @(negedge sys_clk);
    {mgmt_wr, mgmt_bcast_wr, mgmt_wdata} = {2'h0, ~d};
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(negedge sys_clk);
    {mgmt_addr, mgmt_rd} = {a, 1'b1};
    @(negedge sys_clk);
    mgmt_rd = 1'b0;
    q = mgmt_rdata;
  endtask
  // Mode bits only take effect after this
  task automatic sreset();
    @(negedge sys_clk);
    soft_reset = 1'b1;
    @(negedge sys_clk);
    soft_reset = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/pecx_regs_assertions.sv ***
// Port checks for the register bank
`timescale 1ns/1ps
`default_nettype none
module pecx_regs_assertions
  import pecx_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              soft_reset,
  input wire logic [4:0]        mgmt_addr,
  input wire logic              mgmt_wr,
  input wire logic              mgmt_bcast_wr,
  input wire logic              mgmt_rd,
  input wire logic [15:0]       mgmt_wdata,
  input wire logic [15:0]       mgmt_rdata,
  input wire logic              bcast_enable,
  input wire logic              force_link_pass,
  input wire logic              jabber_disable,
  input wire logic              echo_disable,
  input wire logic              sqe_disable,
  input wire pecx_squelch_type  squelch_mode,
  input wire pecx_media_type    media_mode,
  input wire pecx_override_type media_override,
  input wire logic              far_end_loopback
);
  // ==========
  // Access shapes
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence wr_at(logic [4:0] a);
    (mgmt_wr || mgmt_bcast_wr) && mgmt_addr == a && !soft_reset;
  endsequence
  sequence rd_at(logic [4:0] a);
    mgmt_rd && mgmt_addr == a && !soft_reset;
  endsequence
  force_link_a: assert property (wr_at(5'h16) |=> force_link_pass == $past(mgmt_wdata[15])) else $error("force");
  disable_bits_a: assert property (wr_at(5'h16) |=> {jabber_disable, echo_disable, sqe_disable}
    == $past(mgmt_wdata[14:12])) else $error("disables");
  squelch_set_a: assert property (wr_at(5'h16) |=> squelch_mode == $past(mgmt_wdata[11:10])) else $error("squelch");
  bcast_set_a: assert property (wr_at(5'h16) |=> bcast_enable == $past(mgmt_wdata[0])) else $error("bcast");
  override_set_a: assert property (wr_at(5'h17) |=> media_override == $past(mgmt_wdata[7:6])
    && far_end_loopback == $past(mgmt_wdata[3])) else $error("override");
  mode_hold_a: assert property (!soft_reset |=> $stable(media_mode)) else $error("mode moved");
  mode_read_a: assert property (rd_at(5'h17) |=> mgmt_rdata[10:8] == $past(media_mode)) else $error("mode read");
  cnt_upper_a: assert property (mgmt_rd && mgmt_addr inside {[5'h13:5'h15]} |=> mgmt_rdata[15:8] == 8'h00)
    else $error("count upper");
  rsvd_zero_a: assert property (rd_at(5'h17) |=> mgmt_rdata[15:13] == 3'h0 && mgmt_rdata[5:4] == 2'h0
    && mgmt_rdata[2:0] == 3'h0) else $error("reserved");
endmodule
bind pecx_regs pecx_regs_assertions chk_i (.sys_clk, .rst, .soft_reset, .mgmt_addr, .mgmt_wr, .mgmt_bcast_wr,
  .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .bcast_enable, .force_link_pass, .jabber_disable, .echo_disable,
  .sqe_disable, .squelch_mode, .media_mode, .media_override, .far_end_loopback);
`default_nettype wire

// *** tb/tb_pecx_regs.sv ***
// Self-checking bench for the error counter and extended control bank
`timescale 1ns/1ps
`default_nettype none
module tb_pecx_regs;
  import pecx_pkg::*;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              soft_reset, mgmt_wr, mgmt_bcast_wr, mgmt_rd, bcast_enable, force_link_pass;
  logic              jabber_disable, echo_disable, sqe_disable, mac_1000x, far_end_loopback;
  logic              auto_media_sense_pref_copper;
  logic              ten_link_active = 1'b0;
  logic [4:0]        mgmt_addr;
  logic [4:0]        ev = 5'h0;
  logic [15:0]       mgmt_wdata, mgmt_rdata, q;
  pecx_squelch_type  squelch_mode;
  pecx_media_type    media_mode;
  pecx_override_type media_override;
  int                fail_count = 0;
  int                n_compared = 0;
  always #2 sys_clk = ~sys_clk;
  pecx_regs DUT (.sys_clk, .rst, .soft_reset, .mgmt_addr, .mgmt_wr, .mgmt_bcast_wr, .mgmt_rd, .mgmt_wdata,
    .mgmt_rdata, .bcast_enable, .rx_error_event(ev[0]), .false_carrier_event(ev[1]), .copper_disc_event(ev[2]),
    .eof_error_event(ev[3]), .ten_disc_event(ev[4]), .ten_link_active, .force_link_pass, .jabber_disable,
    .echo_disable, .sqe_disable, .squelch_mode, .mac_1000x, .auto_media_sense_pref_copper, .media_mode,
    .media_override, .far_end_loopback);
  pecx_host host (.sys_clk, .mgmt_rdata, .soft_reset, .mgmt_addr, .mgmt_wr, .mgmt_bcast_wr, .mgmt_rd, .mgmt_wdata);
  // ==========
  // Tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    host.rd(a, q);
    chk(q, e);
  endtask
  // Held high for n cycles, so events arrive back to back
  task automatic pulse(input int i, input int n);
    @(negedge sys_clk);
    ev[i] = 1'b1;
    repeat (n) @(negedge sys_clk);
    ev[i] = 1'b0;
  endtask
  task automatic complete_run();
    $display("TB: compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // Tests
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    rchk(5'h13, 16'h0000);
    rchk(5'h16, 16'h3200);
    rchk(5'h17, 16'h0000);
    $display("TB: reset test done");
    for (int i = 0; i < 3; i++)
    begin
      pulse(i, i + 3);
      rchk(5'h13 + 5'(i), 16'(i + 3));
      rchk(5'h13 + 5'(i), 16'h0000);
    end
    pulse(0, 300);
    rchk(5'h13, 16'h00ff);
    host.wr(5'h13, 16'hffff, 1'b0);
    rchk(5'h13, 16'h0000);
    rchk(5'h12, 16'h0000);
    $display("TB: counter test done");
    ten_link_active = 1'b1;
    pulse(3, 1);
    pulse(4, 1);
    rchk(5'h16, 16'h33c0);
    rchk(5'h16, 16'h3240);
    ten_link_active = 1'b0;
    host.wr(5'h16, 16'hf7ff, 1'b0);
    rchk(5'h16, 16'hf641);
    chk(16'(bcast_enable), 16'h0001);
    chk({12'h000, force_link_pass, jabber_disable, echo_disable, sqe_disable}, 16'h000f);
    host.sreset();
    rchk(5'h16, 16'hf641);
    host.wr(5'h16, 16'h5400, 1'b1);
    rchk(5'h16, 16'h5400);
    host.sreset();
    rchk(5'h16, 16'h3000);
    $display("TB: sticky test done");
    for (int i = 0; i < 8; i++)
    begin
      host.wr(5'h16, {4'h0, 2'(i), 10'h0}, 1'b0);
      chk(16'(squelch_mode), 16'(i % 4));
      host.wr(5'h17, {3'h7, i[0], ~i[0], 3'(i), 2'(i), 2'h3, i[0], 3'h7}, 1'b0);
      chk(16'(media_mode), 16'(i == 0 ? 0 : i - 1));
      host.sreset();
      rchk(5'h17, {3'h0, i[0], ~i[0], 3'(i), 2'(i), 2'h0, i[0], 3'h0});
      chk({11'h000, mac_1000x, auto_media_sense_pref_copper, media_override, far_end_loopback},
        {11'h000, i[0], ~i[0], 2'(i), i[0]});
    end
    $display("TB: mode test done");
    complete_run();
  end
  initial
  begin
    #200000;
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
